// File: pkg/spm_pkg.sv
// Purpose: shared constants and types for the shunt power monitor
// Assumes: 20 MHz system clock, 16-bit register words, 3-bit pointer
// Notes:   conversion times are kept in microseconds and turned into cycles
package spm_pkg;

  // register pointer values
  localparam logic [2:0] REG_SETUP   = 3'h0; // setup_control
  localparam logic [2:0] REG_SENSE   = 3'h1; // sense_voltage_result
  localparam logic [2:0] REG_RAIL    = 3'h2; // rail_voltage_result
  localparam logic [2:0] REG_POWER   = 3'h3; // power_result
  localparam logic [2:0] REG_CURRENT = 3'h4; // current_result
  localparam logic [2:0] REG_SCALE   = 3'h5; // scale_factor
  localparam logic [2:0] REG_ALSEL   = 3'h6; // alert_select
  localparam logic [2:0] REG_TRIP    = 3'h7; // trip_threshold

  // reset values
  localparam logic [15:0] SETUP_RST = 16'h4127; // wide range, continuous shunt and bus
  localparam logic [15:0] SCALE_RST = 16'h0000; // uncalibrated
  localparam logic [15:0] ALSEL_RST = 16'h0000; // no alert source
  localparam logic [15:0] TRIP_RST  = 16'h0000;

  // setup_control fields
  localparam int SETUP_SWRST_BIT = 15;
  localparam int SETUP_RANGE_BIT = 12; // shunt_range_select, 0 = +-81.92 mV
  localparam int SETUP_AVG_LSB   = 9;
  localparam int SETUP_BUSCT_LSB = 6;
  localparam int SETUP_SHCT_LSB  = 3;
  localparam int SETUP_MODE_LSB  = 0;
  localparam int MODE_SHUNT_BIT  = 0;
  localparam int MODE_BUS_BIT    = 1;
  localparam int MODE_CONT_BIT   = 2;

  // alert_select fields
  localparam int ALSEL_SOL_BIT  = 15; // shunt_over_limit_enable
  localparam int ALSEL_SUL_BIT  = 14;
  localparam int ALSEL_BOL_BIT  = 13;
  localparam int ALSEL_BUL_BIT  = 12;
  localparam int ALSEL_POL_BIT  = 11;
  localparam int ALSEL_CNVR_BIT = 10;
  localparam int ALSEL_AFF_BIT  = 4;
  localparam int ALSEL_CVRF_BIT = 3;
  localparam int ALSEL_APOL_BIT = 1;
  localparam int ALSEL_LEN_BIT  = 0;
  localparam logic [15:0] ALSEL_WMASK = 16'hFC03; // software-writable bits

  // arithmetic scaling
  localparam int          CUR_SHIFT_WIDE   = 11;          // current = shunt*cal/2048
  localparam int          CUR_SHIFT_NARROW = 9;           // narrow range codes are 4x finer
  localparam logic [16:0] POWER_DIVISOR    = 17'h04E20;   // 20000, gives 32x current step
  localparam int          DIV_STEPS        = 32;

  // timing
  localparam int CLK_MHZ = 20;
  localparam int unsigned CONV_TIME_US [8] = '{140, 204, 332, 588, 1100, 2116, 4156, 8244};
  localparam int unsigned AVG_SHIFT    [8] = '{0, 2, 4, 6, 7, 8, 9, 10};

  // serial port bus address, arbitrary default
  localparam logic [6:0] DEV_ADDR = 7'h40;

  typedef enum logic [3:0] {
    SER_IDLE = 4'b0000, SER_ADDR = 4'b0001, SER_AACK = 4'b0010,
    SER_PTR  = 4'b0011, SER_PACK = 4'b0100, SER_WDAT = 4'b0101,
    SER_WACK = 4'b0110, SER_RDAT = 4'b0111, SER_RACK = 4'b1000
  } spm_ser_e;

  typedef enum logic [2:0] {
    MEAS_IDLE = 3'b000, MEAS_SHUNT = 3'b001, MEAS_BUS = 3'b010,
    MEAS_UPDATE = 3'b011, MEAS_POWER = 3'b100
  } spm_meas_e;

  // one completed measurement set
  typedef struct packed {
    logic signed [15:0] shunt;
    logic        [15:0] bus;
    logic signed [15:0] current;
  } spm_result_s;

endpackage : spm_pkg

// File: testbench/spm_host_model.sv
// Purpose: host controller on the two-wire register port
// Assumes: device answers within one low phase of the clock line
// Notes:   clock line stands high between frames; data line has a pull-up
`timescale 1ns/1ns
`default_nettype none
module spm_host_model
  import spm_pkg::*;
(
  input  wire logic clk,
  input  wire logic sdaOe,
  output var  logic sclIn,
  output wire logic sdaIn
);
  logic pull; // host pulls the data line low
  // wired-and with pull-up: low when either side pulls
  assign sdaIn = !(pull || sdaOe);
  // idle bus, both lines high
  initial begin
    sclIn = 1'h1;
    pull  = 1'h0;
  end
  // one bit: set a cycle after the fall, read late in the high phase
  task automatic bitx(input logic b, output logic r);
    sclIn = 1'h0;
    @(negedge clk);
    pull = !b;
    repeat (3) @(negedge clk);
    sclIn = 1'h1;
    repeat (4) @(negedge clk);
    r = sdaIn;
  endtask : bitx
  // data falls while the clock line is high
  task automatic start();
    pull = 1'h1;
    repeat (4) @(negedge clk);
  endtask : start
  // data rises while the clock line is high
  task automatic stop();
    sclIn = 1'h0;
    @(negedge clk);
    pull = 1'h1;
    repeat (3) @(negedge clk);
    sclIn = 1'h1;
    repeat (4) @(negedge clk);
    pull = 1'h0;
    repeat (4) @(negedge clk);
  endtask : stop
  // eight bits msb first, then the ninth (acknowledge) bit
  task automatic xfer(input logic [7:0] w, input logic a, output logic [7:0] r,
                      output logic ack);
    for (int i = 7; i >= 0; i--) bitx(w[i], r[i]);
    bitx(a, ack);
  endtask : xfer
  // pointer then word, msb first; nak set if any byte went unanswered
  task automatic regWrite(input logic [6:0] adr, input logic [2:0] p,
                          input logic [15:0] d, output logic nak);
    logic [7:0] r;
    logic [3:0] k;
    start();
    xfer({adr, 1'h0}, 1'h1, r, k[3]);
    xfer({5'h00, p}, 1'h1, r, k[2]);
    xfer(d[15:8], 1'h1, r, k[1]);
    xfer(d[7:0], 1'h1, r, k[0]);
    stop();
    nak = |k;
  endtask : regWrite
  // set pointer, then read msb (host acks) and lsb (host nacks)
  task automatic regRead(input logic [6:0] adr, input logic [2:0] p,
                         output logic [15:0] d, output logic nak);
    logic [7:0] r;
    logic [3:0] k;
    start();
    xfer({adr, 1'h0}, 1'h1, r, k[0]);
    xfer({5'h00, p}, 1'h1, r, k[1]);
    stop();
    start();
    xfer({adr, 1'h1}, 1'h1, r, k[2]);
    xfer(8'hFF, 1'h0, d[15:8], k[3]);
    xfer(8'hFF, 1'h1, d[7:0], k[3]);
    stop();
    nak = |k[2:0];
  endtask : regRead
endmodule : spm_host_model
`default_nettype wire

// File: testbench/spm_monitor_asserts.sv
// Purpose: port-level checks of the shunt power monitor
// Assumes: host paces the clock line at 400 ns, driving on falling clk
// Notes:   register contents are judged by the bench, not here
`timescale 1ns/1ns
`default_nettype none
module spm_monitor_asserts (
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        sclIn,
  input wire logic        sdaIn,
  input wire logic        sdaOut,
  input wire logic        sdaOe,
  input wire logic        alertOut,
  input wire logic        alertOe,
  input wire logic [15:0] shuntAdc,
  input wire logic [15:0] busAdc
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  logic [7:0] oeCnt_q;   // cycles the data line has been pulled
  logic [2:0] sclHi_q;   // consecutive high samples of the clock line
  logic       busSeen_q; // any host traffic since reset
  // saturating, so a long hold never wraps back to a small count
  always_ff @(posedge clk) begin
    oeCnt_q <= (rst || !sdaOe) ? 8'h00 : oeCnt_q + {7'h00, oeCnt_q != 8'hFF};
  end
  // high-phase length, saturating at 7
  always_ff @(posedge clk) begin
    sclHi_q <= (rst || !sclIn) ? 3'h0 : sclHi_q + {2'h0, sclHi_q != 3'h7};
  end
  // alert_select is zero after reset, so only a host write can arm it
  always_ff @(posedge clk) begin
    busSeen_q <= rst ? 1'h0 : (busSeen_q || !sclIn);
  end
  property p_drive_zero; sdaOut == 1'h0 && alertOut == 1'h0; endproperty
  a_drive_zero: assert property (p_drive_zero) else $error("pin drives a high level");
  property p_rst_quiet; $fell(rst) |-> (!sdaOe && !alertOe) [*4]; endproperty
  a_rst_quiet: assert property (p_rst_quiet) else $error("pins active after reset");
  property p_alert_src; $rose(alertOe) |-> busSeen_q; endproperty
  a_alert_src: assert property (p_alert_src) else $error("alert with no source set");
  property p_ack_on_low; $changed(sdaOe) |-> !$past(sclIn, 3); endproperty
  a_ack_on_low: assert property (p_ack_on_low) else $error("data moved off low phase");
  property p_hold_high; sclHi_q >= 3'h4 |-> $stable(sdaOe); endproperty
  a_hold_high: assert property (p_hold_high) else $error("data moved in high phase");
  property p_oe_bounded; oeCnt_q <= 8'h64; endproperty
  a_oe_bounded: assert property (p_oe_bounded) else $error("data line held too long");
  property p_oe_min; $rose(sdaOe) |=> sdaOe [*6]; endproperty
  a_oe_min: assert property (p_oe_min) else $error("data bit held too short");
  property p_alert_gap; $changed(alertOe) |=> $stable(alertOe) [*8]; endproperty
  a_alert_gap: assert property (p_alert_gap) else $error("alert toggled twice fast");
  c_ack: cover property ($rose(sdaOe));
  c_alert_on: cover property ($rose(alertOe));
  c_alert_off: cover property ($fell(alertOe));
endmodule : spm_monitor_asserts
bind spm_shunt_power_monitor spm_monitor_asserts u_asserts (
  .clk(clk), .rst(rst), .sclIn(sclIn), .sdaIn(sdaIn), .sdaOut(sdaOut), .sdaOe(sdaOe),
  .alertOut(alertOut), .alertOe(alertOe), .shuntAdc(shuntAdc), .busAdc(busAdc));
`default_nettype wire

// File: testbench/spm_shunt_power_monitor_tb_top.sv
// Purpose: self-checking bench for the shunt power monitor registers
// Assumes: one clock per microsecond, so a default set spends 2200 clocks converting
// Notes:   front-end codes are driven directly by the bench
`timescale 1ns/1ns
`default_nettype none
module spm_shunt_power_monitor_tb_top
  import spm_pkg::*;
;
  localparam int SET = 2 * CONV_TIME_US[4] + 100; // shunt + bus + power margin
  logic        clk;      // 20 MHz system clock
  logic        rst;      // synchronous reset
  wire  logic  sclIn;    // clock line from host
  wire  logic  sdaIn;    // resolved data line
  logic        sdaOut;   // device data drive value
  logic        sdaOe;    // device pulls data low
  logic        alertOut; // alert drive value
  logic        alertOe;  // alert pulled
  logic [15:0] shuntAdc; // front-end shunt code
  logic [15:0] busAdc;   // front-end bus code
  int          nErrors;  // mismatches
  int          checks;   // comparisons
  logic [15:0] rd;       // last word read
  logic        nak;      // last access refused
  spm_shunt_power_monitor #(.CYCLES_PER_US(1)) dut (
    .clk(clk), .rst(rst), .sclIn(sclIn), .sdaIn(sdaIn), .sdaOut(sdaOut), .sdaOe(sdaOe),
    .alertOut(alertOut), .alertOe(alertOe), .shuntAdc(shuntAdc), .busAdc(busAdc));
  spm_host_model host (.clk(clk), .sdaOe(sdaOe), .sclIn(sclIn), .sdaIn(sdaIn));
  // 50 ns period
  initial begin
    clk = 1'h0;
    forever #25 clk = ~clk;
  end
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      nErrors++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  // a read must be acknowledged and return the expected word
  task automatic rdChk(input logic [2:0] p, input logic [15:0] exp);
    host.regRead(DEV_ADDR, p, rd, nak);
    chk({15'h0000, nak}, 16'h0000);
    chk(rd, exp);
  endtask : rdChk
  task automatic wr(input logic [2:0] p, input logic [15:0] d);
    host.regWrite(DEV_ADDR, p, d, nak);
    chk({15'h0000, nak}, 16'h0000);
  endtask : wr
  // bounded wait on the alert pin; running out ends the run
  task automatic waitAlert(input logic v, input int n);
    int i;
    for (i = 0; i < n && alertOe !== v; i++) @(negedge clk);
    if (i == n) begin
      nErrors++;
      give_verdict();
    end
    chk({15'h0000, alertOe}, {15'h0000, v});
  endtask : waitAlert
  task automatic defaults();
    rdChk(REG_SETUP, SETUP_RST);
    rdChk(REG_SCALE, SCALE_RST);
    rdChk(REG_ALSEL, ALSEL_RST);
    rdChk(REG_TRIP, TRIP_RST);
    chk({15'h0000, alertOe}, 16'h0000);
  endtask : defaults
  task automatic give_verdict();
    $display("checks=%0d errors=%0d", checks, nErrors);
    if (nErrors == 0 && checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : give_verdict
  // 12 V rail, 48 mV across the shunt
  initial begin
    nErrors = 0;
    checks = 0;
    rst = 1'h1;
    shuntAdc = 16'h4B00;
    busAdc = 16'h1D4C;
    repeat (8) @(negedge clk);
    rst = 1'h0;
    repeat (4) @(negedge clk);
    defaults();
    $display("test defaults done");
    repeat (SET) @(negedge clk);
    rdChk(REG_SENSE, 16'h4B00);
    rdChk(REG_RAIL, 16'h1D4C);
    rdChk(REG_CURRENT, 16'h0000);
    rdChk(REG_POWER, 16'h0000);
    $display("test uncalibrated done");
    // 500 uA step: inside 8x the 10 A / 32768 minimum
    wr(REG_SCALE, 16'h0500);
    repeat (2 * SET) @(negedge clk);
    rdChk(REG_CURRENT, 16'h2EE0);
    rdChk(REG_POWER, 16'h1194);
    shuntAdc = 16'hB500; // reverse current
    repeat (2 * SET) @(negedge clk);
    rdChk(REG_SENSE, 16'hB500);
    rdChk(REG_CURRENT, 16'hD120);
    rdChk(REG_POWER, 16'h1194);
    $display("test calibrated done");
    // equal to the limit is not over it
    wr(REG_TRIP, 16'h7080);
    shuntAdc = 16'h7080;
    wr(REG_ALSEL, 16'h8000);
    repeat (SET) @(negedge clk);
    chk({15'h0000, alertOe}, 16'h0000);
    shuntAdc = 16'h7081;
    waitAlert(1'h1, 2 * SET);
    shuntAdc = 16'h4B00;
    waitAlert(1'h0, 2 * SET);
    $display("test overcurrent done");
    host.regRead(DEV_ADDR ^ 7'h01, REG_SETUP, rd, nak);
    chk({15'h0000, nak}, 16'h0001);
    wr(REG_SETUP, 16'h4047);
    rdChk(REG_SETUP, 16'h4047);
    rdChk(REG_ALSEL, 16'h8008);
    wr(REG_ALSEL, 16'h0400);
    waitAlert(1'h1, 600);
    $display("test ready and setup done");
    // power cycle stand-in: everything back to defaults
    rst = 1'h1;
    repeat (8) @(negedge clk);
    rst = 1'h0;
    repeat (4) @(negedge clk);
    defaults();
    $display("test second reset done");
    give_verdict();
  end
endmodule : spm_shunt_power_monitor_tb_top
`default_nettype wire

// File: verilog/spm_shunt_power_monitor.sv
// Purpose: register-level behaviour of a shunt current, bus voltage and power monitor
// Assumes: adc codes arrive from front-end logic on clk; serial bus pins are asynchronous
// Notes:   registers are reached over the two-wire serial port only
`timescale 1ns/1ns
`default_nettype none

module spm_shunt_power_monitor
  import spm_pkg::*;
#(
  parameter int CYCLES_PER_US = CLK_MHZ // shorten in simulation
) (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        sclIn,
  input  wire logic        sdaIn,
  output var  logic        sdaOut,
  output var  logic        sdaOe,
  output var  logic        alertOut,
  output var  logic        alertOe,
  input  wire logic [15:0] shuntAdc,
  input  wire logic [15:0] busAdc
);

  // cycles of one conversion for a 3-bit time code
  function automatic logic [19:0] convCycles(input logic [2:0] ct);
    convCycles = 20'(CONV_TIME_US[ct] * CYCLES_PER_US);
  endfunction : convCycles

  // ---------------- registers ----------------
  logic [15:0] setup_q;      // setup_control
  logic [15:0] scale_q;      // scale_factor
  logic [15:0] alSel_q;      // writable part of alert_select
  logic [15:0] trip_q;       // trip_threshold
  spm_result_s res_q;        // last published measurement set
  logic [15:0] power_q;      // power_result
  logic        cvrf_q;       // conversion ready flag
  logic        aff_q;        // alert function flag
  logic        trigger_q;    // single-shot request

  // serial port side
  logic [2:0]  sclSync_q, sdaSync_q; // three-stage samplers
  logic        sclF_q, sdaF_q;       // debounced pin levels
  spm_ser_e    ser_q;
  logic [3:0]  bitCnt_q;
  logic [7:0]  shReg_q;
  logic [7:0]  txReg_q;
  logic [2:0]  ptr_q;
  logic        rw_q;
  logic        hiByte_q;     // next data byte is the high one
  logic [7:0]  loHold_q;     // low half of a word being read
  logic [7:0]  hiHold_q;     // high half of a word being written
  logic        nack_q;
  logic        regWr_q;      // one-cycle register write strobe
  logic [15:0] regWrData_q;
  logic        alselRd_q;    // alert_select was read

  // ---------------- pin sampling ----------------
  // a level counts only once the second and third stages agree
  logic sclStable, sdaStable, sclRise, sclFall, startCond, stopCond, sdaNow;
  assign sclStable = (sclSync_q[1] == sclSync_q[2]);
  assign sdaStable = (sdaSync_q[1] == sdaSync_q[2]);
  assign sclRise   = sclStable && sclSync_q[2] && !sclF_q;
  assign sclFall   = sclStable && !sclSync_q[2] && sclF_q;
  assign startCond = sclF_q && sclStable && sclSync_q[2] && sdaStable && !sdaSync_q[2] && sdaF_q;
  assign stopCond  = sclF_q && sclStable && sclSync_q[2] && sdaStable && sdaSync_q[2] && !sdaF_q;
  // level sdaF_q takes this edge; our own release settles only as the clock line
  // rises, so the filtered copy would still show the acknowledge
  assign sdaNow    = sdaStable ? sdaSync_q[2] : sdaF_q;

  always_ff @(posedge clk) begin
    if (rst) begin
      sclSync_q <= 3'h7;
      sdaSync_q <= 3'h7;
      sclF_q    <= 1'b1;
      sdaF_q    <= 1'b1;
    end else begin
      sclSync_q <= {sclSync_q[1:0], sclIn};
      sdaSync_q <= {sdaSync_q[1:0], sdaIn};
      if (sclStable) sclF_q <= sclSync_q[2];
      if (sdaStable) sdaF_q <= sdaSync_q[2];
    end
  end

  // read data mux; shunt and current results are signed codes as stored
  logic [15:0] rdWord;
  always_comb begin
    unique case (ptr_q)
      REG_SETUP:   rdWord = setup_q;
      REG_SENSE:   rdWord = res_q.shunt;
      REG_RAIL:    rdWord = res_q.bus;
      REG_POWER:   rdWord = power_q;
      REG_CURRENT: rdWord = res_q.current;
      REG_SCALE:   rdWord = scale_q;
      REG_ALSEL:   rdWord = alSel_q | (16'(aff_q) << ALSEL_AFF_BIT)
                                    | (16'(cvrf_q) << ALSEL_CVRF_BIT);
      REG_TRIP:    rdWord = trip_q;
    endcase
  end

  // ---------------- serial port engine ----------------
  // bits sampled on scl rise, sda changed on scl fall; pointer then msb-first words
  always_ff @(posedge clk) begin
    regWr_q   <= 1'b0;
    alselRd_q <= 1'b0;
    if (rst) begin
      ser_q       <= SER_IDLE;
      bitCnt_q    <= 4'h0;
      shReg_q     <= 8'h00;
      txReg_q     <= 8'h00;
      ptr_q       <= REG_SETUP;
      rw_q        <= 1'b0;
      hiByte_q    <= 1'b1;
      loHold_q    <= 8'h00;
      hiHold_q    <= 8'h00;
      nack_q      <= 1'b0;
      sdaOe       <= 1'b0;
      regWrData_q <= 16'h0000;
    end else if (startCond) begin
      ser_q    <= SER_ADDR;  // repeated start keeps the pointer
      bitCnt_q <= 4'h0;
      hiByte_q <= 1'b1;      // a lone high byte is dropped
      sdaOe    <= 1'b0;
    end else if (stopCond) begin
      ser_q <= SER_IDLE;
      sdaOe <= 1'b0;
    end else if (sclRise) begin
      // receiving states shift in one bit
      if (ser_q == SER_ADDR || ser_q == SER_PTR || ser_q == SER_WDAT) begin
        shReg_q  <= {shReg_q[6:0], sdaNow};
        bitCnt_q <= bitCnt_q + 4'h1;
      end else if (ser_q == SER_RACK) begin
        nack_q <= sdaNow;
      end
    end else if (sclFall) begin
      unique case (ser_q)
        SER_IDLE: ;
        SER_ADDR: if (bitCnt_q == 4'h8) begin
          if (shReg_q[7:1] == DEV_ADDR) begin
            ser_q <= SER_AACK;
            rw_q  <= shReg_q[0];
            sdaOe <= 1'b1;  // acknowledge
          end else begin
            ser_q <= SER_IDLE; // not addressed, stay off the bus
          end
        end
        SER_AACK: begin
          bitCnt_q <= 4'h0;
          if (rw_q) begin
            // capture the whole word now so both halves are coherent
            ser_q     <= SER_RDAT;
            sdaOe     <= ~rdWord[15];
            txReg_q   <= {rdWord[14:8], 1'b0};
            loHold_q  <= rdWord[7:0];
            hiByte_q  <= 1'b0;
            bitCnt_q  <= 4'h1;
            alselRd_q <= (ptr_q == REG_ALSEL);
          end else begin
            ser_q <= SER_PTR;
            sdaOe <= 1'b0;
          end
        end
        SER_PTR: if (bitCnt_q == 4'h8) begin
          ptr_q <= shReg_q[2:0];
          ser_q <= SER_PACK;
          sdaOe <= 1'b1;
        end
        SER_PACK, SER_WACK: begin
          ser_q    <= SER_WDAT;
          sdaOe    <= 1'b0;
          bitCnt_q <= 4'h0;
        end
        SER_WDAT: if (bitCnt_q == 4'h8) begin
          ser_q <= SER_WACK;
          sdaOe <= 1'b1;
          if (hiByte_q) begin
            hiHold_q <= shReg_q;
          end else begin
            regWr_q     <= 1'b1;
            regWrData_q <= {hiHold_q, shReg_q};
          end
          hiByte_q <= ~hiByte_q;
        end
        SER_RDAT: begin
          if (bitCnt_q == 4'h8) begin
            ser_q <= SER_RACK;
            sdaOe <= 1'b0;   // release for the host acknowledge
          end else begin
            sdaOe    <= ~txReg_q[7];
            txReg_q  <= {txReg_q[6:0], 1'b0};
            bitCnt_q <= bitCnt_q + 4'h1;
          end
        end
        SER_RACK: begin
          if (nack_q) begin
            ser_q <= SER_IDLE;
          end else begin
            // further bytes alternate low then high of a fresh snapshot
            ser_q    <= SER_RDAT;
            bitCnt_q <= 4'h1;
            if (hiByte_q) begin
              sdaOe    <= ~rdWord[15];
              txReg_q  <= {rdWord[14:8], 1'b0};
              loHold_q <= rdWord[7:0];
            end else begin
              sdaOe   <= ~loHold_q[7];
              txReg_q <= {loHold_q[6:0], 1'b0};
            end
            hiByte_q <= ~hiByte_q;
          end
        end
        default: ser_q <= SER_IDLE; // unused state codes
      endcase
    end
  end

  // open-drain data pin only ever pulls low
  always_ff @(posedge clk) sdaOut <= 1'b0;

  // ---------------- register file ----------------
  // power-up and soft reset both restore every setting
  logic swReset;
  assign swReset = regWr_q && ptr_q == REG_SETUP && regWrData_q[SETUP_SWRST_BIT];

  always_ff @(posedge clk) begin
    trigger_q <= 1'b0;
    if (rst || swReset) begin
      setup_q <= SETUP_RST;
      scale_q <= SCALE_RST;
      alSel_q <= ALSEL_RST;
      trip_q  <= TRIP_RST;
    end else if (regWr_q) begin
      unique case (ptr_q)
        REG_SETUP: begin
          setup_q   <= regWrData_q & 16'h7FFF;
          trigger_q <= ~regWrData_q[SETUP_MODE_LSB + MODE_CONT_BIT];
        end
        REG_SCALE: scale_q <= regWrData_q & 16'h7FFF;
        REG_ALSEL: alSel_q <= regWrData_q & ALSEL_WMASK;
        REG_TRIP:  trip_q  <= regWrData_q;
        default: ; // result registers ignore writes
      endcase
    end
  end

  // ---------------- conversion sequencer ----------------
  spm_meas_e           meas_q;
  logic [19:0]         convCnt_q;
  logic [9:0]          avgCnt_q;
  logic signed [25:0]  accShunt_q;
  logic [25:0]         accBus_q;
  logic                divStart_q;
  logic                divBusy_q;
  logic                cvrSet_q;  // one-cycle conversion-ready event
  logic [2:0]          modeF, avgF, shCtF, busCtF;
  logic [9:0]          avgLast;
  assign modeF   = setup_q[SETUP_MODE_LSB +: 3];
  assign avgF    = setup_q[SETUP_AVG_LSB +: 3];
  assign shCtF   = setup_q[SETUP_SHCT_LSB +: 3];
  assign busCtF  = setup_q[SETUP_BUSCT_LSB +: 3];
  assign avgLast = 10'((11'h001 << AVG_SHIFT[avgF]) - 11'h001);

  // calibrated current; zero while uncalibrated
  logic signed [31:0] curProd;
  logic signed [15:0] curNew;
  logic signed [15:0] shuntNew;
  assign shuntNew = 16'(accShunt_q >>> AVG_SHIFT[avgF]);
  assign curProd  = shuntNew * $signed({1'b0, scale_q[14:0]});
  assign curNew   = (scale_q == 16'h0000) ? 16'sh0000 :
                    setup_q[SETUP_RANGE_BIT] ? 16'(curProd >>> CUR_SHIFT_NARROW)
                                             : 16'(curProd >>> CUR_SHIFT_WIDE);

  // shunt then bus, each with its own time; averaging wraps both
  // counts end on >= so a shorter time written mid-conversion cannot overrun
  always_ff @(posedge clk) begin
    divStart_q <= 1'b0;
    cvrSet_q   <= 1'b0;
    if (rst || swReset) begin
      meas_q     <= MEAS_IDLE;
      convCnt_q  <= 20'h00000;
      avgCnt_q   <= 10'h000;
      accShunt_q <= 26'sh0000000;
      accBus_q   <= 26'h0000000;
      res_q      <= '0;
    end else begin
      unique case (meas_q)
        MEAS_IDLE: if ((modeF[MODE_CONT_BIT] || trigger_q) && modeF[1:0] != 2'b00) begin
          meas_q    <= MEAS_SHUNT;
          convCnt_q <= 20'h00000;
        end
        MEAS_SHUNT: begin
          if (!modeF[MODE_SHUNT_BIT] || convCnt_q >= convCycles(shCtF) - 20'h00001) begin
            if (modeF[MODE_SHUNT_BIT]) accShunt_q <= accShunt_q + 26'(signed'(shuntAdc));
            meas_q    <= MEAS_BUS;
            convCnt_q <= 20'h00000;
          end else begin
            convCnt_q <= convCnt_q + 20'h00001;
          end
        end
        MEAS_BUS: begin
          if (!modeF[MODE_BUS_BIT] || convCnt_q >= convCycles(busCtF) - 20'h00001) begin
            if (modeF[MODE_BUS_BIT]) accBus_q <= accBus_q + 26'(busAdc[14:0]);
            convCnt_q <= 20'h00000;
            if (avgCnt_q == avgLast) begin
              meas_q <= MEAS_UPDATE;
            end else begin
              avgCnt_q <= avgCnt_q + 10'h001;
              meas_q   <= MEAS_SHUNT;
            end
          end else begin
            convCnt_q <= convCnt_q + 20'h00001;
          end
        end
        MEAS_UPDATE: begin
          // voltages publish regardless of calibration
          if (modeF[MODE_SHUNT_BIT]) begin
            res_q.shunt   <= shuntNew;
            res_q.current <= curNew;
          end
          if (modeF[MODE_BUS_BIT]) res_q.bus <= 16'(accBus_q >> AVG_SHIFT[avgF]);
          accShunt_q <= 26'sh0000000;
          accBus_q   <= 26'h0000000;
          avgCnt_q   <= 10'h000;
          divStart_q <= 1'b1;
          meas_q     <= MEAS_POWER;
        end
        MEAS_POWER: if (!divStart_q && !divBusy_q) begin
          cvrSet_q <= 1'b1;
          meas_q   <= modeF[MODE_CONT_BIT] ? MEAS_SHUNT : MEAS_IDLE;
        end
        default: meas_q <= MEAS_IDLE;
      endcase
    end
  end

  // ---------------- power divider ----------------
  // restoring division by a constant; one bit per clock is ample per conversion
  logic [31:0] divNum_q;
  logic [16:0] divRem_q;
  logic [4:0]  divCnt_q;
  logic [16:0] remShift;
  logic [15:0] curMag;
  assign remShift = {divRem_q[15:0], divNum_q[31]};
  assign curMag   = res_q.current[15] ? 16'(-res_q.current) : res_q.current;

  always_ff @(posedge clk) begin
    if (rst || swReset) begin
      divBusy_q <= 1'b0;
      divNum_q  <= 32'h00000000;
      divRem_q  <= 17'h00000;
      divCnt_q  <= 5'h00;
      power_q   <= 16'h0000;
    end else if (divStart_q) begin
      divBusy_q <= 1'b1;
      divNum_q  <= curMag * {1'b0, res_q.bus[14:0]};
      divRem_q  <= 17'h00000;
      divCnt_q  <= 5'h00;
    end else if (divBusy_q) begin
      if (remShift >= POWER_DIVISOR) begin
        divRem_q <= remShift - POWER_DIVISOR;
        divNum_q <= {divNum_q[30:0], 1'b1};
      end else begin
        divRem_q <= remShift;
        divNum_q <= {divNum_q[30:0], 1'b0};
      end
      divCnt_q <= divCnt_q + 5'h01;
      if (divCnt_q == 5'(DIV_STEPS - 1)) divBusy_q <= 1'b0;
    end else if (meas_q == MEAS_POWER) begin
      // saturate; zero current already forces zero power
      power_q <= (divNum_q[31:16] != 16'h0000) ? 16'hFFFF : divNum_q[15:0];
    end
  end

  // ---------------- alert ----------------
  // limits compare in raw result codes; only the power limit needs calibration
  logic faultNow;
  assign faultNow =
      (alSel_q[ALSEL_SOL_BIT] && res_q.shunt > $signed(trip_q)) ||
      (alSel_q[ALSEL_SUL_BIT] && res_q.shunt < $signed(trip_q)) ||
      (alSel_q[ALSEL_BOL_BIT] && res_q.bus > trip_q) ||
      (alSel_q[ALSEL_BUL_BIT] && res_q.bus < trip_q) ||
      (alSel_q[ALSEL_POL_BIT] && power_q > trip_q);

  // flags: a set in the same cycle as a read-clear wins
  always_ff @(posedge clk) begin
    if (rst || swReset) begin
      cvrf_q <= 1'b0;
      aff_q  <= 1'b0;
    end else begin
      if (cvrSet_q) cvrf_q <= 1'b1;
      else if (alselRd_q) cvrf_q <= 1'b0;
      // evaluated once per published set, so response tracks the conversion rate
      if (cvrSet_q && faultNow) aff_q <= 1'b1;
      else if (cvrSet_q && !alSel_q[ALSEL_LEN_BIT]) aff_q <= 1'b0;
      else if (alselRd_q && alSel_q[ALSEL_LEN_BIT]) aff_q <= 1'b0;
    end
  end

  // open drain; default polarity pulls low while active
  always_ff @(posedge clk) begin
    alertOut <= 1'b0;
    if (rst) alertOe <= 1'b0;
    else alertOe <= (aff_q || (alSel_q[ALSEL_CNVR_BIT] && cvrf_q)) ^ alSel_q[ALSEL_APOL_BIT];
  end

endmodule : spm_shunt_power_monitor

`default_nettype wire
